// [inc/crcu_pkg.sv]
// constants shared by the checksum unit: register map, fields, reset values
// assumes a 32-bit bus slave with byte addressing and the bus clock
package crcu_pkg;
    localparam logic [7:0]  OFS_DATA    = 8'h00;
    localparam logic [7:0]  OFS_SCRATCH = 8'h04;
    localparam logic [7:0]  OFS_CONTROL = 8'h08;
    localparam logic [7:0]  OFS_SEED    = 8'h10;
    localparam logic [7:0]  OFS_COEF    = 8'h14;

    localparam logic [31:0] RST_DATA    = 32'hffffffff;
    localparam logic [7:0]  RST_SCRATCH = 8'h00;
    localparam logic [7:0]  RST_CONTROL = 8'h00;
    localparam logic [31:0] RST_SEED    = 32'hffffffff;
    localparam logic [31:0] RST_COEF    = 32'h04c11db7;

    localparam int CTL_RESTART  = 0;
    localparam int CTL_WSEL_LO  = 3;
    localparam int CTL_FLIP_LO  = 5;
    localparam int CTL_OUT_FLIP = 7;
    localparam int SCRATCH_W    = 8;

    // generator width select codes
    localparam logic [1:0] WSEL_32 = 2'h0;
    localparam logic [1:0] WSEL_16 = 2'h1;
    localparam logic [1:0] WSEL_8  = 2'h2;
    localparam logic [1:0] WSEL_7  = 2'h3;

    // input flip select codes
    localparam logic [1:0] FLIP_NONE = 2'h0;
    localparam logic [1:0] FLIP_BYTE = 2'h1;
    localparam logic [1:0] FLIP_HALF = 2'h2;
    localparam logic [1:0] FLIP_WORD = 2'h3;

    // bus transfer sizes and byte counts; one byte is folded per cycle
    localparam logic [2:0] HSIZE_BYTE = 3'h0;
    localparam logic [2:0] HSIZE_HALF = 3'h1;
    localparam logic [2:0] BYTES_B    = 3'h1;
    localparam logic [2:0] BYTES_H    = 3'h2;
    localparam logic [2:0] BYTES_W    = 3'h4;

    localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
    localparam logic [1:0] HRESP_OKAY        = 2'h0;
endpackage

// [inc/crcu_eng_if.sv]
// carrier between the register front end and the checksum engine
// assumes both ends run on the same bus clock
`timescale 1ns/1ps
interface crcu_eng_if;
    logic        start;
    logic [31:0] data;
    logic [2:0]  nbytes;
    logic        load;
    logic [31:0] load_val;
    logic [1:0]  wsel;
    logic [31:0] poly;
    logic        ready;
    logic        busy;
    logic [31:0] crc;

    modport front (output start, data, nbytes, load, load_val, wsel, poly,
                   input ready, busy, crc);
    modport eng   (input start, data, nbytes, load, load_val, wsel, poly,
                   output ready, busy, crc);
endinterface

// [core/crcu_bitrev.sv]
// reverses the bit order of a W-bit vector
// assumes nothing; pure wiring
`timescale 1ns/1ps
module crcu_bitrev #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] din,
    output wire logic [W-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign dout[i] = din[W-1-i];
        end
    endgenerate
endmodule

// [core/crcu_engine.sv]
// checksum engine: folds one byte per clock, msb first, over the selected width
// assumes configuration stays still while busy and load wins over start
`timescale 1ns/1ps
module crcu_engine (
    input  wire logic  clk,
    input  wire logic  rst_n,
    crcu_eng_if.eng    e
);
    logic [31:0] crc_r, crc_nxt;
    logic [31:0] sh_r, sh_nxt;
    logic [2:0]  cnt_r, cnt_nxt;
    logic [31:0] fold;
    logic [31:0] mask;
    logic [4:0]  top;
    logic        fb;

    always_comb begin
        case (e.wsel)
            crcu_pkg::WSEL_32: begin mask = 32'hffffffff; top = 5'h1f; end
            crcu_pkg::WSEL_16: begin mask = 32'h0000ffff; top = 5'h0f; end
            crcu_pkg::WSEL_8:  begin mask = 32'h000000ff; top = 5'h07; end
            default:           begin mask = 32'h0000007f; top = 5'h06; end
        endcase
    end

    always_comb begin
        fold = crc_r;
        fb   = 1'b0;
        for (int b = 7; b >= 0; b--) begin
            fb   = fold[top] ^ sh_r[24+b];
            fold = (fold << 1) & mask;
            if (fb) begin
                fold = fold ^ (e.poly & mask);
            end
        end
    end

    assign e.busy  = (cnt_r != 3'h0);
    // the next word may enter on the last byte cycle, so back-to-back words leave the engine no idle cycle
    assign e.ready = (cnt_r <= 3'h1);
    assign e.crc   = crc_r;

    always_comb begin
        crc_nxt = crc_r;
        sh_nxt  = sh_r;
        cnt_nxt = cnt_r;
        if (cnt_r != 3'h0) begin
            crc_nxt = fold;
            sh_nxt  = {sh_r[23:0], 8'h00};
            cnt_nxt = cnt_r - 3'h1;
        end
        if (e.load) begin
            crc_nxt = e.load_val;
            cnt_nxt = 3'h0;
        end else if (e.start && e.ready) begin
            case (e.nbytes)
                crcu_pkg::BYTES_B: sh_nxt = {e.data[7:0], 24'h000000};
                crcu_pkg::BYTES_H: sh_nxt = {e.data[15:0], 16'h0000};
                default:           sh_nxt = e.data;
            endcase
            cnt_nxt = e.nbytes;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_r <= crcu_pkg::RST_DATA;
            sh_r  <= 32'h00000000;
            cnt_r <= 3'h0;
        end else begin
            crc_r <= crc_nxt;
            sh_r  <= sh_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// [core/crcu_top.sv]
// checksum unit top: bus slave with registers, input buffer and flip logic
// assumes a single-master bus on clk; reads take one wait state, data reads more until nothing is in flight
// Notes on behaviour
// - data writes feed the checksum; reset all ones
// - data reads return latest finished checksum
// - narrow data and result sit low
// - scratch byte read/write, upper bits zero
// - restart leaves the scratch byte alone
// - output flip reverses result bit order
// - input flip by byte, half, word
// - width select 32, 16, 8, 7
// - restart loads data with the seed
// - restart bit clears itself, reads zero
// - control resets zero, reserved bits zero
// - seed register holds 32-bit start value
// - coefficients register resets to default polynomial
// - seed write also loads data register
// - latency four, two, one cycles
// - buffer takes a second write, no stall
`timescale 1ns/1ps
module crcu_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic      [1:0]  hresp
);
    crcu_eng_if eif ();
    localparam logic HTRANS_BIT = crcu_pkg::HTRANS_NONSEQ_BIT[1];

    crcu_engine u_eng (
        .clk   (clk),
        .rst_n (rst_n),
        .e     (eif)
    );

    // address phase capture
    logic       dp_r, dp_nxt;
    logic       dp_wr_r, dp_wr_nxt;
    logic [7:0] dp_addr_r, dp_addr_nxt;
    logic [2:0] dp_size_r, dp_size_nxt;
    logic       rd_done_r, rd_done_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    // registers
    logic [7:0]  scratch_r, scratch_nxt;
    logic        output_bit_flip_r, output_bit_flip_nxt;
    logic [1:0]  input_bit_flip_select_r, input_bit_flip_select_nxt;
    logic [1:0]  generator_width_select_r, generator_width_select_nxt;
    logic [31:0] seed_r, seed_nxt;
    logic [31:0] coef_r, coef_nxt;

    // input buffer
    logic        pend_r, pend_nxt;
    logic [31:0] pend_data_r, pend_data_nxt;
    logic [2:0]  pend_n_r, pend_n_nxt;

    logic        wr_phase;
    logic        rd_phase;
    logic        dr_wr;
    logic        dr_wr_ok;
    logic        rd_can;
    logic        restart;
    logic        seed_wr;
    logic        hi_clr, ctl_ok;
    logic [2:0]  wr_bytes;
    logic [1:0]  flip_eff;
    logic [31:0] in_byte, in_half, in_word, in_data;
    logic [31:0] out_32;
    logic [15:0] out_16;
    logic [7:0]  out_8;
    logic [6:0]  out_7;
    logic [31:0] out_val;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_byte
            crcu_bitrev #(.W(8)) u_rb (
                .din  (hwdata[8*g+7:8*g]),
                .dout (in_byte[8*g+7:8*g])
            );
        end
        for (g = 0; g < 2; g++) begin : g_half
            crcu_bitrev #(.W(16)) u_rh (
                .din  (hwdata[16*g+15:16*g]),
                .dout (in_half[16*g+15:16*g])
            );
        end
    endgenerate

    crcu_bitrev #(.W(32)) u_rw (
        .din  (hwdata),
        .dout (in_word)
    );

    crcu_bitrev #(.W(32)) u_o32 (
        .din  (eif.crc),
        .dout (out_32)
    );
    crcu_bitrev #(.W(16)) u_o16 (
        .din  (eif.crc[15:0]),
        .dout (out_16)
    );
    crcu_bitrev #(.W(8)) u_o8 (
        .din  (eif.crc[7:0]),
        .dout (out_8)
    );
    crcu_bitrev #(.W(7)) u_o7 (
        .din  (eif.crc[6:0]),
        .dout (out_7)
    );

    assign wr_phase = dp_r && dp_wr_r;
    assign rd_phase = dp_r && !dp_wr_r;
    assign dr_wr    = wr_phase && (dp_addr_r == crcu_pkg::OFS_DATA);
    // stall only when both buffer and engine are occupied
    assign dr_wr_ok = !(pend_r && !eif.ready);
    // a data read waits until nothing is in flight
    assign rd_can   = (dp_addr_r != crcu_pkg::OFS_DATA) || (!eif.busy && !pend_r);
    // restart on writing one to bit 0
    assign restart  = wr_phase && (dp_addr_r == crcu_pkg::OFS_CONTROL)
                      && ctl_ok && hwdata[crcu_pkg::CTL_RESTART];
    assign seed_wr  = wr_phase && (dp_addr_r == crcu_pkg::OFS_SEED);
    assign hi_clr   = hwdata[31:8] == 24'h000000;
    assign ctl_ok   = hi_clr && hwdata[2:1] == 2'h0;

    always_comb begin
        case (dp_size_r)
            crcu_pkg::HSIZE_BYTE: wr_bytes = crcu_pkg::BYTES_B;
            crcu_pkg::HSIZE_HALF: wr_bytes = crcu_pkg::BYTES_H;
            default:              wr_bytes = crcu_pkg::BYTES_W;
        endcase
    end

    // flip unit never wider than the write
    always_comb begin
        flip_eff = input_bit_flip_select_r;
        if ((dp_size_r == crcu_pkg::HSIZE_BYTE) && (flip_eff != crcu_pkg::FLIP_NONE)) begin
            flip_eff = crcu_pkg::FLIP_BYTE;
        end else if ((dp_size_r == crcu_pkg::HSIZE_HALF)
                     && (flip_eff == crcu_pkg::FLIP_WORD)) begin
            flip_eff = crcu_pkg::FLIP_HALF;
        end
        case (flip_eff)
            crcu_pkg::FLIP_BYTE: in_data = in_byte;
            crcu_pkg::FLIP_HALF: in_data = in_half;
            crcu_pkg::FLIP_WORD: in_data = (dp_size_r == crcu_pkg::HSIZE_HALF) ?
                                           {16'h0000, in_word[31:16]} : in_word;
            default:             in_data = hwdata;
        endcase
    end

    // flip over selected width, result kept low
    always_comb begin
        case (generator_width_select_r)
            crcu_pkg::WSEL_32: out_val = out_32;
            crcu_pkg::WSEL_16: out_val = {16'h0000, out_16};
            crcu_pkg::WSEL_8:  out_val = {24'h000000, out_8};
            default:           out_val = {25'h0000000, out_7};
        endcase
        if (!output_bit_flip_r) begin
            out_val = eif.crc;
        end
    end

    // handshake
    always_comb begin
        hreadyout = 1'b1;
        if (rd_phase && !rd_done_r) begin
            hreadyout = 1'b0;
        end
        if (dr_wr && !dr_wr_ok) begin
            hreadyout = 1'b0;
        end
    end
    assign hresp  = crcu_pkg::HRESP_OKAY;
    assign hrdata = rdata_r;

    // bus phase tracking and read data
    always_comb begin
        dp_nxt      = dp_r;
        dp_wr_nxt   = dp_wr_r;
        dp_addr_nxt = dp_addr_r;
        dp_size_nxt = dp_size_r;
        rd_done_nxt = 1'b0;
        rdata_nxt   = rdata_r;
        if (hready) begin
            dp_nxt      = hsel && (htrans[1] == HTRANS_BIT);
            dp_wr_nxt   = hwrite;
            dp_addr_nxt = haddr;
            dp_size_nxt = hsize;
        end
        if (rd_phase && !rd_done_r && rd_can) begin
            rd_done_nxt = 1'b1;
            case (dp_addr_r)
                crcu_pkg::OFS_DATA:    rdata_nxt = out_val;
                crcu_pkg::OFS_SCRATCH: rdata_nxt = {24'h000000, scratch_r};
                crcu_pkg::OFS_CONTROL: rdata_nxt = {24'h000000, output_bit_flip_r,
                                                    input_bit_flip_select_r,
                                                    generator_width_select_r, 3'h0};
                crcu_pkg::OFS_SEED:    rdata_nxt = seed_r;
                crcu_pkg::OFS_COEF:    rdata_nxt = coef_r;
                default:               rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // register writes
    always_comb begin
        scratch_nxt                = scratch_r;
        output_bit_flip_nxt        = output_bit_flip_r;
        input_bit_flip_select_nxt  = input_bit_flip_select_r;
        generator_width_select_nxt = generator_width_select_r;
        seed_nxt                   = seed_r;
        coef_nxt                   = coef_r;
        if (wr_phase) begin
            case (dp_addr_r)
                crcu_pkg::OFS_SCRATCH: if (hi_clr) scratch_nxt = hwdata[crcu_pkg::SCRATCH_W-1:0];
                crcu_pkg::OFS_CONTROL: if (ctl_ok) begin
                    output_bit_flip_nxt        = hwdata[crcu_pkg::CTL_OUT_FLIP];
                    input_bit_flip_select_nxt  = hwdata[crcu_pkg::CTL_FLIP_LO +: 2];
                    generator_width_select_nxt = hwdata[crcu_pkg::CTL_WSEL_LO +: 2];
                end
                crcu_pkg::OFS_SEED:    seed_nxt = hwdata;
                // coefficients, narrow ones taken from low bits
                crcu_pkg::OFS_COEF:    coef_nxt = hwdata;
                default:               scratch_nxt = scratch_r;
            endcase
        end
    end

    // engine feed and input buffer
    always_comb begin
        pend_nxt      = pend_r;
        pend_data_nxt = pend_data_r;
        pend_n_nxt    = pend_n_r;
        eif.start     = 1'b0;
        eif.data      = in_data;
        eif.nbytes    = wr_bytes;
        // restart or seed write loads the data register and drops queued input
        eif.load      = restart || seed_wr;
        eif.load_val  = seed_wr ? hwdata : seed_r;
        eif.wsel      = generator_width_select_r;
        eif.poly      = coef_r;
        if (pend_r && eif.ready) begin
            eif.start  = 1'b1;
            eif.data   = pend_data_r;
            eif.nbytes = pend_n_r;
            pend_nxt   = 1'b0;
        end
        // a write goes straight in or waits in the buffer
        if (dr_wr && dr_wr_ok) begin
            if (!pend_r && eif.ready) begin
                eif.start = 1'b1;
            end else begin
                pend_nxt      = 1'b1;
                pend_data_nxt = in_data;
                pend_n_nxt    = wr_bytes;
            end
        end
        if (eif.load) begin
            pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_r                     <= 1'b0;
            dp_wr_r                  <= 1'b0;
            dp_addr_r                <= 8'h00;
            dp_size_r                <= 3'h0;
            rd_done_r                <= 1'b0;
            rdata_r                  <= 32'h00000000;
            scratch_r                <= crcu_pkg::RST_SCRATCH;
            output_bit_flip_r        <= crcu_pkg::RST_CONTROL[crcu_pkg::CTL_OUT_FLIP];
            input_bit_flip_select_r  <= crcu_pkg::RST_CONTROL[crcu_pkg::CTL_FLIP_LO +: 2];
            generator_width_select_r <= crcu_pkg::RST_CONTROL[crcu_pkg::CTL_WSEL_LO +: 2];
            seed_r                   <= crcu_pkg::RST_SEED;
            coef_r                   <= crcu_pkg::RST_COEF;
            pend_r                   <= 1'b0;
            pend_data_r              <= 32'h00000000;
            pend_n_r                 <= 3'h0;
        end else begin
            dp_r                     <= dp_nxt;
            dp_wr_r                  <= dp_wr_nxt;
            dp_addr_r                <= dp_addr_nxt;
            dp_size_r                <= dp_size_nxt;
            rd_done_r                <= rd_done_nxt;
            rdata_r                  <= rdata_nxt;
            scratch_r                <= scratch_nxt;
            output_bit_flip_r        <= output_bit_flip_nxt;
            input_bit_flip_select_r  <= input_bit_flip_select_nxt;
            generator_width_select_r <= generator_width_select_nxt;
            seed_r                   <= seed_nxt;
            coef_r                   <= coef_nxt;
            pend_r                   <= pend_nxt;
            pend_data_r              <= pend_data_nxt;
            pend_n_r                 <= pend_n_nxt;
        end
    end
endmodule

// [dv/crcu_checker.sv]
// bus-level checks for the checksum unit, bound to its top module
// assumes one master on clk and the register values set through this bus
`timescale 1ns/1ps
module crcu_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic [1:0]  hresp
);
    logic        dp_r;
    logic        dw_r;
    logic [7:0]  da_r;
    logic [7:0]  ctl_r;
    logic [7:0]  scr_r;
    logic [7:0]  idle_r;
    logic [31:0] seed_r;
    logic [31:0] coef_r;
    logic        fresh_r;
    wire         take  = hsel & htrans[1] & hready;
    wire         wdone = dp_r & dw_r & hreadyout;
    wire         rdone = dp_r & ~dw_r & hreadyout;

    // shadow copy of what software wrote; reserved-bit writes are dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_r    <= 1'b0;
            dw_r    <= 1'b0;
            da_r    <= 8'h00;
            ctl_r   <= 8'h00;
            scr_r   <= 8'h00;
            idle_r  <= 8'h00;
            seed_r  <= crcu_pkg::RST_SEED;
            coef_r  <= crcu_pkg::RST_COEF;
            fresh_r <= 1'b0;
        end else begin
            if (hreadyout) begin
                dp_r <= take;
                dw_r <= hwrite;
                da_r <= haddr;
            end
            if (wdone && da_r == crcu_pkg::OFS_DATA) begin
                idle_r <= 8'h00;
            end else if (idle_r != 8'hff) begin
                idle_r <= idle_r + 8'h01;
            end
            if (wdone) begin
                case (da_r)
                    crcu_pkg::OFS_DATA: fresh_r <= 1'b0;
                    crcu_pkg::OFS_SCRATCH: begin
                        if (hwdata[31:8] == 24'h0) scr_r <= hwdata[7:0];
                    end
                    crcu_pkg::OFS_CONTROL: begin
                        if (hwdata[31:8] == 24'h0 && hwdata[2:1] == 2'h0) begin
                            ctl_r <= {hwdata[7:3], 3'h0};
                            if (hwdata[0]) fresh_r <= 1'b1;
                        end
                    end
                    crcu_pkg::OFS_SEED: begin
                        seed_r  <= hwdata;
                        fresh_r <= 1'b1;
                    end
                    crcu_pkg::OFS_COEF: coef_r <= hwdata;
                    default: ;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_scratch_rd;
        rdone && da_r == crcu_pkg::OFS_SCRATCH |-> hrdata == {24'h0, scr_r};
    endproperty
    a_scratch_rd: assert property (p_scratch_rd) else $error("scratch read mismatch");
    property p_ctl_rd;
        rdone && da_r == crcu_pkg::OFS_CONTROL |-> hrdata == {24'h0, ctl_r};
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control read mismatch");
    property p_seed_rd;
        rdone && da_r == crcu_pkg::OFS_SEED |-> hrdata == seed_r;
    endproperty
    a_seed_rd: assert property (p_seed_rd) else $error("seed read mismatch");
    property p_coef_rd;
        rdone && da_r == crcu_pkg::OFS_COEF |-> hrdata == coef_r;
    endproperty
    a_coef_rd: assert property (p_coef_rd) else $error("coefficient read mismatch");
    property p_seed_load;
        rdone && da_r == crcu_pkg::OFS_DATA && fresh_r && !ctl_r[7] && ctl_r[4:3] == 2'h0
            |-> hrdata == seed_r;
    endproperty
    a_seed_load: assert property (p_seed_load) else $error("data not loaded with seed");
    property p_read_bound;
        dp_r && !hreadyout |-> ##[1:16] hreadyout;
    endproperty
    a_read_bound: assert property (p_read_bound) else $error("wait state too long");
    property p_reg_wr_nowait;
        dp_r && dw_r && da_r != crcu_pkg::OFS_DATA |-> hreadyout;
    endproperty
    a_reg_wr_nowait: assert property (p_reg_wr_nowait) else $error("register write stalled");
    property p_data_wr_nowait;
        dp_r && dw_r && da_r == crcu_pkg::OFS_DATA && idle_r > 8'h08 |-> hreadyout && hresp == 2'h0;
    endproperty
    a_data_wr_nowait: assert property (p_data_wr_nowait) else $error("data write stalled");
endmodule

bind crcu_top crcu_checker u_chk (
    .clk       (clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp)
);

// [dv/tb_top.sv]
// self-checking bench for the checksum unit: reset values, checksums, timing
// assumes hready is fed back from hreadyout as a single-slave bus would
`timescale 1ns/1ps
module tb_top;
    typedef struct {logic [7:0] a; logic [31:0] e;} crcu_rrow_t;
    typedef struct {logic [7:0] ctl; logic [31:0] poly; int nb;} crcu_crow_t;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [31:0] exp;
    logic        hreadyout;
    logic [1:0]  hresp;
    int          miscompares = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          wt;
    int          w;
    int          lat[3];
    wire         hready = hreadyout;
    crcu_rrow_t  rrows[6] = '{'{8'h00, 32'hffffffff}, '{8'h04, 32'h0}, '{8'h08, 32'h0},
                              '{8'h10, 32'hffffffff}, '{8'h14, 32'h04c11db7}, '{8'h0c, 32'h0}};
    crcu_crow_t  crows[9] = '{'{8'h00, 32'h04c11db7, 4}, '{8'h20, 32'h04c11db7, 4},
                              '{8'h40, 32'h04c11db7, 4}, '{8'he0, 32'h04c11db7, 4},
                              '{8'h08, 32'h00001021, 2}, '{8'h10, 32'h00000007, 1},
                              '{8'h18, 32'h00000009, 1}, '{8'h88, 32'h00008005, 4},
                              '{8'h28, 32'h00001021, 2}};

    crcu_top u_dut (
        .clk       (clk),
        .rst_n     (rst_n),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp)
    );

    always #50 clk = ~clk;

    function automatic logic [31:0] flip(input logic [31:0] v, input int n);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < n; i++) r[i] = v[n - 1 - i];
        return r;
    endfunction

    // reference fold: msb first, input flip unit clamped to the write size
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d,
            input logic [31:0] p, input int nb, input int w, input logic [1:0] fl);
        logic [31:0] m;
        logic [31:0] x;
        logic        fb;
        int          u;
        int          b;
        m = (w == 32) ? 32'hffffffff : ((32'h1 << w) - 32'h1);
        u = (fl == 2'h0) ? 0 : (fl == 2'h1) ? 8 : (fl == 2'h2) ? 16 : 32;
        if (u > nb * 8) u = nb * 8;
        x = d;
        for (int j = 0; j < nb * 8 && u > 0; j++) begin
            b = j - j % u;
            x[j] = d[b + u - 1 - (j - b)];
        end
        for (int i = nb * 8 - 1; i >= 0; i--) begin
            fb = c[w - 1] ^ x[i];
            c = (c << 1) & m;
            if (fb) c = c ^ (p & m);
        end
        return c;
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one transfer: address phase, then hold data until hreadyout is high
    task automatic bus(input logic wr, input logic [7:0] a, input logic [2:0] sz,
            input logic [31:0] wd, output logic [31:0] rv, output int waits);
        waits = 0;
        @(negedge clk);
        hsel = 1'b1;
        htrans = 2'h2;
        hwrite = wr;
        haddr = a;
        hsize = sz;
        @(negedge clk);
        hsel = 1'b0;
        htrans = 2'h0;
        hwdata = wd;
        while (hreadyout !== 1'b1 && waits < 40) begin
            waits++;
            @(negedge clk);
        end
        rv = hrdata;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
        bus(1'b1, a, sz, d, rd, wt);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 3'h2, 32'h0, rd, wt);
        chk(nm, e, rd);
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        foreach (rrows[i]) rdchk("reset value", rrows[i].a, rrows[i].e);
        foreach (crows[i]) begin
            w = (crows[i].ctl[4:3] == 2'h3) ? 7 : (32 >> crows[i].ctl[4:3]);
            wr(8'h14, crows[i].poly, 3'h2);
            wr(8'h08, {24'h0, crows[i].ctl} | 32'h1, 3'h2);
            exp = crcu_pkg::RST_SEED;
            for (int k = 0; k < 2; k++) begin
                wr(8'h00, k ? 32'h96e5071f : 32'h1a2b3c4d, 3'(crows[i].nb >> 1));
                exp = crc_step(exp, k ? 32'h96e5071f : 32'h1a2b3c4d, crows[i].poly,
                               crows[i].nb, w, crows[i].ctl[6:5]);
            end
            if (crows[i].ctl[7]) exp = flip(exp, w);
            rdchk("checksum", 8'h00, exp);
        end
        $display("done table cases");
        for (int k = 0; k < 3; k++) begin
            wr(8'h08, 32'h1, 3'h2);
            wr(8'h00, 32'h0, 3'(k));
            bus(1'b0, 8'h00, 3'h2, 32'h0, rd, lat[k]);
        end
        chk("half minus byte waits", 32'h1, 32'(lat[1] - lat[0]));
        chk("word minus half waits", 32'h2, 32'(lat[2] - lat[1]));
        wr(8'h14, crcu_pkg::RST_COEF, 3'h2);
        wr(8'h08, 32'h1, 3'h2);
        @(negedge clk);
        hsel = 1'b1;
        htrans = 2'h2;
        hwrite = 1'b1;
        haddr = 8'h00;
        @(negedge clk);
        hwdata = 32'h1a2b3c4d;
        chk("first write ready", 32'h1, {31'h0, hreadyout});
        @(negedge clk);
        hsel = 1'b0;
        htrans = 2'h0;
        hwdata = 32'h96e5071f;
        chk("second write ready", 32'h1, {31'h0, hreadyout});
        @(posedge clk);
        exp = crc_step(crcu_pkg::RST_SEED, 32'h1a2b3c4d, crcu_pkg::RST_COEF, 4, 32, 2'h0);
        exp = crc_step(exp, 32'h96e5071f, crcu_pkg::RST_COEF, 4, 32, 2'h0);
        rdchk("back to back checksum", 8'h00, exp);
        $display("done timing cases");
        wr(8'h04, 32'ha5, 3'h2);
        wr(8'h04, 32'h1ff5a, 3'h2);
        wr(8'h08, 32'hf9, 3'h2);
        wr(8'h08, 32'h6, 3'h2);
        rdchk("scratch", 8'h04, 32'ha5);
        rdchk("control", 8'h08, 32'hf8);
        wr(8'h08, 32'h1, 3'h2);
        wr(8'h10, 32'hcafe0001, 3'h2);
        rdchk("data after seed write", 8'h00, 32'hcafe0001);
        wr(8'h00, 32'h1234, 3'h2);
        wr(8'h08, 32'h1, 3'h2);
        rdchk("data after restart", 8'h00, 32'hcafe0001);
        rdchk("seed", 8'h10, 32'hcafe0001);
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        rdchk("scratch after reset", 8'h04, 32'h0);
        rdchk("data after reset", 8'h00, crcu_pkg::RST_DATA);
        $display("done register cases");
        end_of_test();
    end
endmodule
